/* File: design/tcrs_pkg.sv */
// Shared constants for the transmit clock-rate and clock-select block
`default_nettype none
package tcrs_pkg;
	// Synthesizer multipliers for the two rate-select levels
	localparam logic [4:0] MULT_HIGH = 5'h14;
	localparam logic [4:0] MULT_LOW = 5'h0A;
	// Bits per character and the half point of the character clock
	localparam logic [3:0] BITS_PER_CHAR = 4'hA;
	localparam logic [3:0] CHAR_HALF = 4'h5;
	// Three-level pin codes, two wires per select
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;
	// Number of decoded transmit operating modes
	localparam logic [3:0] MODE_COUNT = 4'h9;
	// Register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_PERIOD = 12'h008;
	// Control field positions and value after reset
	localparam int CTRL_SYNTH_EN = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	// Status field positions
	localparam int ST_RATE = 0;
	localparam int ST_RX_REF = 1;
	localparam int ST_HALF = 2;
	localparam int ST_INVALID = 3;
	localparam int ST_LOCKED = 4;
	localparam int ST_MODE = 8;
	localparam int ST_PHASE = 12;
	localparam int ST_MULT = 16;
	// Number of synchronised pin inputs
	localparam int PIN_COUNT = 12;
endpackage : tcrs_pkg
`default_nettype wire

/* File: design/tcrs_synth.sv */
// Transmit synthesizer model: bit and character clocks from the reference
`default_nettype none
module tcrs_synth #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Control
	input  wire logic             enable,
	input  wire logic             ref_rise,
	input  wire logic [4:0]       mult,
	// Outputs
	output logic                  bit_en,
	output logic [3:0]            bit_cnt,
	output logic                  char_clk,
	output logic [CNT_W-1:0]      period
);
	logic [CNT_W-1:0] cnt;          // Cycles since last reference edge
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] next_period;
	logic [CNT_W:0]   acc;          // Phase accumulator
	logic [CNT_W:0]   next_acc;
	logic [CNT_W:0]   sum;          // Accumulator plus step
	logic             next_bit_en;
	logic [3:0]       next_bit_cnt;
	logic             next_char_clk;

	// Period measurement and phase accumulation; a limitation: the
	// multiplier must not exceed the measured period, else bits are lost
	always_comb
	begin
		next_cnt = cnt + 1'b1;
		next_period = period;
		next_acc = acc;
		next_bit_en = 1'b0;
		next_bit_cnt = bit_cnt;
		next_char_clk = char_clk;
		sum = acc + {{(CNT_W-4){1'b0}}, mult};
		if (ref_rise)
		begin
			// Latch the reference period in clock cycles
			next_period = cnt + 1'b1;
			next_cnt = '0;
		end
		if (enable && period != '0)
		begin
			// RULE1 RULE2 multiply by select
			if (sum >= {1'b0, period})
			begin
				next_acc = sum - {1'b0, period};
				next_bit_en = 1'b1;
				// Bit counter wraps once per character
				if (bit_cnt == tcrs_pkg::BITS_PER_CHAR - 1'b1)
					next_bit_cnt = '0;
				else
					next_bit_cnt = bit_cnt + 1'b1;
				// RULE9 character clock from bits
				next_char_clk = (next_bit_cnt < tcrs_pkg::CHAR_HALF);
			end
			else
				next_acc = sum;
		end
	end

	// Register the synthesizer state
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt <= '0;
			period <= '0;
			acc <= '0;
			bit_en <= 1'b0;
			bit_cnt <= '0;
			char_clk <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			period <= next_period;
			acc <= next_acc;
			bit_en <= next_bit_en;
			bit_cnt <= next_bit_cnt;
			char_clk <= next_char_clk;
		end
	end
endmodule : tcrs_synth
`default_nettype wire

/* File: design/tcrs_top.sv */
// Transmit clock-rate select, receive clock select and mode decode
//
// Function
// RULE1 - Rate high: synthesizer multiplies reference by 20
// RULE2 - Rate low: synthesizer multiplies reference by 10
// RULE3 - Reference source, rate high: half-rate receive clocks
// RULE4 - Reference source, rate low: full-rate receive clocks
// RULE5 - Host avoids high/mid clock select at high rate
// RULE6 - Host input clock matches transmit clock frequency
// RULE7 - Track input phase in reset, hold afterwards
// RULE8 - Decode two three-level inputs into nine modes
// RULE9 - True/complement transmit clock, one or two times reference
// RULE10 - Host changes selects only during transmit reset
`default_nettype none
module tcrs_top #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	// Pins from the host
	input  wire logic        REFERENCE_CLOCK_IN,
	input  wire logic        RX_RECOVERED_CLOCK,
	input  wire logic        TX_SYNTH_RATE_SELECT,
	input  wire logic        RX_CLOCK_SOURCE_SELECT,
	input  wire logic [1:0]  TX_INPUT_CLOCK_SOURCE_SELECT,
	input  wire logic        TX_PARALLEL_INPUT_CLOCK,
	input  wire logic        TX_PATH_RESET_N,
	input  wire logic [3:0]  TX_OPERATING_MODE_SEL,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Clock outputs
	output logic             TX_SYNTH_CLOCK_OUT_P,
	output logic             TX_SYNTH_CLOCK_OUT_N,
	output logic             TX_BIT_EN,
	output logic             RX_OUTPUT_CLOCK_PAIR_P,
	output logic             RX_OUTPUT_CLOCK_PAIR_N,
	output logic             RX_OUTPUT_CLOCK_AUX,
	// Status outputs
	output logic      [4:0]  TX_SYNTH_MULT,
	output logic      [3:0]  TX_OPERATING_MODE,
	output logic      [3:0]  TX_INPUT_PHASE,
	output logic             TX_INPUT_PHASE_LOCKED,
	output logic             TX_CONFIG_INVALID,
	output logic             RX_HALF_RATE
);
	localparam int N = tcrs_pkg::PIN_COUNT;

	// Decode a three-level code; the unused code reads as mid
	function automatic logic [1:0] lvl3(input logic [1:0] code);
		lvl3 = (code == 2'h3) ? tcrs_pkg::LVL_MID : code;
	endfunction : lvl3

	// Pin synchroniser stages and filtered result
	logic [N-1:0] s1;
	logic [N-1:0] s2;
	logic [N-1:0] s3;
	logic [N-1:0] filt;
	logic [N-1:0] next_filt;
	logic [N-1:0] pins;             // All host pins gathered

	// Filtered pin views
	logic       ref_lvl;            // Reference clock level
	logic       rec_lvl;            // Recovered clock level
	logic       rate;               // Rate select
	logic       rx_ref;             // Receive clocks from reference
	logic       rx_src_lvl;         // Source select pin, low picks reference
	logic [1:0] tx_sel;             // Input clock source select
	logic       tin_lvl;            // Host transmit input clock
	logic       tx_rst_n;           // Transmit path reset, low active
	logic [3:0] mode_pins;          // Two three-level mode codes

	// Edge detection and derived state
	logic       ref_prev;
	logic       tin_prev;
	logic       ref_rise;
	logic       tin_rise;
	logic [31:0] ctrl;              // Control register
	logic [31:0] next_ctrl;
	logic       bit_en;
	logic [3:0] bit_cnt;
	logic       char_clk;
	logic [CNT_W-1:0] period;
	logic [4:0] next_mult;
	logic [3:0] next_mode;
	logic [3:0] next_phase;
	logic       next_locked;
	logic       next_invalid;
	logic       next_rx_p;
	logic       next_rx_aux;
	logic       next_half;
	logic [1:0] ma;
	logic [1:0] mb;
	logic [31:0] next_prdata;
	logic       next_pslverr;
	logic [31:0] status;
	logic       acc_phase;          // APB access phase

	assign pins = {TX_OPERATING_MODE_SEL, TX_PATH_RESET_N,
		TX_PARALLEL_INPUT_CLOCK, TX_INPUT_CLOCK_SOURCE_SELECT,
		RX_CLOCK_SOURCE_SELECT, TX_SYNTH_RATE_SELECT,
		RX_RECOVERED_CLOCK, REFERENCE_CLOCK_IN};
	assign {mode_pins, tx_rst_n, tin_lvl, tx_sel, rx_src_lvl, rate,
		rec_lvl, ref_lvl} = filt;
	// RULE3 RULE4 low select picks reference
	assign rx_ref = ~rx_src_lvl;
	assign ref_rise = ref_lvl & ~ref_prev;
	assign tin_rise = tin_lvl & ~tin_prev;

	// Accept a pin change once the second and third stages agree
	always_comb
	begin
		for (int i = 0; i < N; i++)
			next_filt[i] = (s2[i] == s3[i]) ? s2[i] : filt[i];
	end

	// Synchroniser and edge history; pins settle through three stages
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			filt <= '0;
			ref_prev <= 1'b0;
			tin_prev <= 1'b0;
		end
		else
		begin
			s1 <= pins;
			s2 <= s1;
			s3 <= s2;
			filt <= next_filt;
			ref_prev <= ref_lvl;
			tin_prev <= tin_lvl;
		end
	end

	// Synthesizer model
	tcrs_synth #(
		.CNT_W    (CNT_W)
	) u_synth (
		.clk      (REF_CLK),
		.rst      (RST),
		.enable   (ctrl[tcrs_pkg::CTRL_SYNTH_EN]),
		.ref_rise (ref_rise),
		.mult     (TX_SYNTH_MULT),
		.bit_en   (bit_en),
		.bit_cnt  (bit_cnt),
		.char_clk (char_clk),
		.period   (period)
	);

	// Clock selection, mode decode and phase tracking
	always_comb
	begin
		// RULE1 RULE2 multiplier from rate
		next_mult = rate ? tcrs_pkg::MULT_HIGH : tcrs_pkg::MULT_LOW;
		// RULE8 nine-way mode decode
		ma = lvl3(mode_pins[3:2]);
		mb = lvl3(mode_pins[1:0]);
		next_mode = ({2'h0, ma} * 4'h3) + {2'h0, mb};
		// Flag a combination the host must avoid; the host keeps RULE5
		next_invalid = rate && (lvl3(tx_sel) != tcrs_pkg::LVL_LOW);
		// RULE3 RULE4 receive clocks follow the selected source, reference or recovered
		next_rx_p = rx_ref ? ref_lvl : rec_lvl;
		next_rx_aux = next_rx_p;
		next_half = rx_ref && rate;
		// RULE7 track phase while in reset
		next_phase = TX_INPUT_PHASE;
		next_locked = tx_rst_n;
		if (!tx_rst_n && tin_rise)
			next_phase = bit_cnt;
	end

	// Register clock outputs and status
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			TX_SYNTH_MULT <= tcrs_pkg::MULT_LOW;
			TX_OPERATING_MODE <= '0;
			TX_CONFIG_INVALID <= 1'b0;
			RX_OUTPUT_CLOCK_PAIR_P <= 1'b0;
			RX_OUTPUT_CLOCK_PAIR_N <= 1'b1;
			RX_OUTPUT_CLOCK_AUX <= 1'b0;
			RX_HALF_RATE <= 1'b0;
			TX_INPUT_PHASE <= '0;
			TX_INPUT_PHASE_LOCKED <= 1'b0;
			TX_SYNTH_CLOCK_OUT_P <= 1'b0;
			TX_SYNTH_CLOCK_OUT_N <= 1'b1;
			TX_BIT_EN <= 1'b0;
		end
		else
		begin
			TX_SYNTH_MULT <= next_mult;
			TX_OPERATING_MODE <= next_mode;
			TX_CONFIG_INVALID <= next_invalid;
			RX_OUTPUT_CLOCK_PAIR_P <= next_rx_p;
			RX_OUTPUT_CLOCK_PAIR_N <= ~next_rx_p;
			RX_OUTPUT_CLOCK_AUX <= next_rx_aux;
			RX_HALF_RATE <= next_half;
			TX_INPUT_PHASE <= next_phase;
			TX_INPUT_PHASE_LOCKED <= next_locked;
			// RULE9 true and complement outputs
			TX_SYNTH_CLOCK_OUT_P <= char_clk;
			TX_SYNTH_CLOCK_OUT_N <= ~char_clk;
			TX_BIT_EN <= bit_en;
		end
	end

	// Status word assembled from live block state
	always_comb
	begin
		status = '0;
		status[tcrs_pkg::ST_RATE] = rate;
		status[tcrs_pkg::ST_RX_REF] = rx_ref;
		status[tcrs_pkg::ST_HALF] = RX_HALF_RATE;
		status[tcrs_pkg::ST_INVALID] = TX_CONFIG_INVALID;
		status[tcrs_pkg::ST_LOCKED] = TX_INPUT_PHASE_LOCKED;
		status[tcrs_pkg::ST_MODE +: 4] = TX_OPERATING_MODE;
		status[tcrs_pkg::ST_PHASE +: 4] = TX_INPUT_PHASE;
		status[tcrs_pkg::ST_MULT +: 5] = TX_SYNTH_MULT;
	end

	// APB decode; zero wait states, so the access phase always completes
	assign PREADY = 1'b1;
	assign acc_phase = PSEL && PENABLE;
	always_comb
	begin
		next_ctrl = ctrl;
		next_prdata = PRDATA;
		next_pslverr = 1'b0;
		if (PSEL && !PENABLE)
		begin
			// Setup phase: prepare read data and error for the access
			next_prdata = '0;
			unique case (PADDR)
				tcrs_pkg::OFS_CTRL:
					next_prdata = ctrl;
				tcrs_pkg::OFS_STATUS:
					next_prdata = status;
				tcrs_pkg::OFS_PERIOD:
					next_prdata = 32'(period);
				default:
					next_pslverr = 1'b1;
			endcase
			// Status and period ignore writes but do not fault
		end
		else if (acc_phase)
		begin
			next_pslverr = PSLVERR;
			// Writes land at the completing edge only
			if (PWRITE && PADDR == tcrs_pkg::OFS_CTRL)
				next_ctrl = {31'h0, PWDATA[tcrs_pkg::CTRL_SYNTH_EN]};
		end
	end

	// Register file and bus answer registers
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			ctrl <= tcrs_pkg::CTRL_RESET;
			PRDATA <= '0;
			PSLVERR <= 1'b0;
		end
		else
		begin
			ctrl <= next_ctrl;
			PRDATA <= next_prdata;
			PSLVERR <= next_pslverr;
		end
	end
endmodule : tcrs_top
`default_nettype wire

/* File: testbench/tcrs_sva.sv */
// Port checker for the transmit clock-rate select block
`default_nettype none
module tcrs_sva (
	// Clock, reset and host pins
	input wire logic       REF_CLK,
	input wire logic       RST,
	input wire logic       REFERENCE_CLOCK_IN,
	input wire logic       RX_RECOVERED_CLOCK,
	input wire logic       TX_SYNTH_RATE_SELECT,
	input wire logic       RX_CLOCK_SOURCE_SELECT,
	input wire logic [1:0] TX_INPUT_CLOCK_SOURCE_SELECT,
	input wire logic       TX_PATH_RESET_N,
	input wire logic [3:0] TX_OPERATING_MODE_SEL,
	// Design outputs
	input wire logic       TX_SYNTH_CLOCK_OUT_P,
	input wire logic       TX_SYNTH_CLOCK_OUT_N,
	input wire logic       TX_BIT_EN,
	input wire logic       RX_OUTPUT_CLOCK_PAIR_P,
	input wire logic       RX_OUTPUT_CLOCK_PAIR_N,
	input wire logic       RX_OUTPUT_CLOCK_AUX,
	input wire logic [4:0] TX_SYNTH_MULT,
	input wire logic [3:0] TX_OPERATING_MODE,
	input wire logic [3:0] TX_INPUT_PHASE,
	input wire logic       TX_INPUT_PHASE_LOCKED,
	input wire logic       TX_CONFIG_INVALID
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge REF_CLK);
	endclocking
	default disable iff (RST);
	logic [9:0] q;   // Cycles with every static pin steady
	logic [4:0] nb;  // Bit pulses since the last character clock rise
	logic [3:0] em;  // Expected mode number
	wire logic [8:0] cfg = {TX_SYNTH_RATE_SELECT, RX_CLOCK_SOURCE_SELECT,
		TX_INPUT_CLOCK_SOURCE_SELECT, TX_PATH_RESET_N, TX_OPERATING_MODE_SEL};
	// Selected receive source, before the five-edge pipeline
	wire logic src = RX_CLOCK_SOURCE_SELECT ? RX_RECOVERED_CLOCK
		: REFERENCE_CLOCK_IN;
	// Code 3 reads as mid
	function automatic logic [3:0] lv(input logic [1:0] x);
		lv = (x == 2'h3) ? 4'h1 : {2'h0, x};
	endfunction : lv
	assign em = 4'h3 * lv(TX_OPERATING_MODE_SEL[3:2])
		+ lv(TX_OPERATING_MODE_SEL[1:0]);
	// Quiet counter; restarts on any static pin change so pipelines can settle
	always_ff @(posedge REF_CLK)
		if (RST || !$stable(cfg))
			q <= 10'h000;
		else if (q != 10'h3FF)
			q <= q + 10'h001;
	// Bit pulses per character clock period
	always_ff @(posedge REF_CLK)
		if ($rose(TX_SYNTH_CLOCK_OUT_P))
			nb <= {4'h0, TX_BIT_EN};
		else
			nb <= nb + {4'h0, TX_BIT_EN};
	a_mult_rate: assert property (
		q > 10'h005 |-> TX_SYNTH_MULT
			== (TX_SYNTH_RATE_SELECT ? 5'h14 : 5'h0A))
		else $error("multiplier wrong");
	a_rx_follow: assert property (
		q > 10'h005 |-> RX_OUTPUT_CLOCK_PAIR_P == $past(src, 5))
		else $error("receive clock wrong");
	a_rx_pair: assert property (
		RX_OUTPUT_CLOCK_PAIR_N == !RX_OUTPUT_CLOCK_PAIR_P
			&& RX_OUTPUT_CLOCK_AUX == RX_OUTPUT_CLOCK_PAIR_P)
		else $error("receive pair wrong");
	a_tx_pair: assert property (
		TX_SYNTH_CLOCK_OUT_N == !TX_SYNTH_CLOCK_OUT_P)
		else $error("transmit pair wrong");
	a_char_bits: assert property (
		$rose(TX_SYNTH_CLOCK_OUT_P) && q > 10'h258 |-> nb == 5'h0A)
		else $error("bits per character wrong");
	a_mode_map: assert property (
		q > 10'h005 |-> TX_OPERATING_MODE == em)
		else $error("mode decode wrong");
	a_bad_combo: assert property (
		q > 10'h005 |-> TX_CONFIG_INVALID == (TX_SYNTH_RATE_SELECT
			&& TX_INPUT_CLOCK_SOURCE_SELECT != 2'h0))
		else $error("invalid flag wrong");
	a_phase_hold: assert property (
		TX_INPUT_PHASE_LOCKED [*2] |-> $stable(TX_INPUT_PHASE))
		else $error("phase moved while locked");
	c_bad: cover property (TX_CONFIG_INVALID);
	c_lock: cover property ($rose(TX_INPUT_PHASE_LOCKED));
	c_fast: cover property (TX_SYNTH_MULT == 5'h14);
endmodule : tcrs_sva
`default_nettype wire

/* File: testbench/tcrs_host.sv */
// Host clock sources facing the clock-select block
`default_nettype none
module tcrs_host #(
	parameter int HALF = 40,
	parameter int SKEW = 7
) (
	input  wire logic clk,
	input  wire logic rate,
	output logic      ref_out,
	output logic      rec_out,
	output logic      tx_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int c;  // Position in one reference period
	initial
		{ref_out, rec_out, tx_out} = 3'h0;
	always @(posedge clk)
	begin
		c <= (c + 1) % (2 * HALF);
		ref_out <= c < HALF;
		rec_out <= (c % 26) < 13;
		// same rate as transmit clock, skewed phase
		tx_out <= rate ? ((c + SKEW) % HALF < HALF / 2)
			: ((c + SKEW) % (2 * HALF) < HALF);
	end
endmodule : tcrs_host
`default_nettype wire

/* File: testbench/tb_transceiver_tx_clock_rate_select.sv */
// Self-checking bench for the transmit clock-rate select block
`default_nettype none
module tb_transceiver_tx_clock_rate_select;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 40;  // Reference half period in cycles
`define CHK(g, e) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			errors++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
		end \
	end
	logic        clk, rst, rate, rxsel, rstn, psel, pen, pwr;
	logic [1:0]  txsel;
	logic [3:0]  msel, md;
	logic [11:0] padr;
	logic [31:0] pwd, prdata;
	logic        pready, pslverr, bit_en, refc, recc, txc;
	logic [64:0] q[$];  // Notes: error flag, data, mask
	logic [64:0] e;
	logic [7:0]  s, nbits;
	int          errors, num_checks, cyc, i;
	tcrs_top #(.CNT_W(16)) dut (.REF_CLK(clk), .RST(rst),
		.REFERENCE_CLOCK_IN(refc), .RX_RECOVERED_CLOCK(recc),
		.TX_SYNTH_RATE_SELECT(rate), .RX_CLOCK_SOURCE_SELECT(rxsel),
		.TX_INPUT_CLOCK_SOURCE_SELECT(txsel), .TX_PARALLEL_INPUT_CLOCK(txc),
		.TX_PATH_RESET_N(rstn), .TX_OPERATING_MODE_SEL(msel),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
		.PWDATA(pwd), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TX_SYNTH_CLOCK_OUT_P(), .TX_SYNTH_CLOCK_OUT_N(), .TX_BIT_EN(bit_en),
		.RX_OUTPUT_CLOCK_PAIR_P(), .RX_OUTPUT_CLOCK_PAIR_N(),
		.RX_OUTPUT_CLOCK_AUX(), .TX_SYNTH_MULT(), .TX_OPERATING_MODE(),
		.TX_INPUT_PHASE(), .TX_INPUT_PHASE_LOCKED(),
		.TX_CONFIG_INVALID(), .RX_HALF_RATE());
	tcrs_host #(.HALF(HALF), .SKEW(7)) host (.clk(clk), .rate(rate),
		.ref_out(refc), .rec_out(recc), .tx_out(txc));
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr
	function automatic logic [3:0] lv(input logic [1:0] x);
		lv = (x == 2'h3) ? 4'h1 : {2'h0, x};
	endfunction : lv
	// One APB transfer; its expected answer is noted first
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [64:0] x);
	begin
		q.push_back(x);
		{psel, pen, pwr, padr, pwd} <= {2'h2, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (!pready)
			@(posedge clk);
		{psel, pen} <= 2'h0;
		@(posedge clk);
	end
	endtask : apb
	task automatic results();
	begin
		$display("errors=%0d checks=%0d", errors, num_checks);
		if (errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask : results
	initial
	begin
		clk = 1'b0;
		forever
			#25 clk = ~clk;
	end
	// Oldest note against each completed access
	always @(posedge clk)
		if (psel && pen && pready)
		begin
			e = q.pop_front();
			`CHK({pslverr, prdata & e[31:0]}, e[64:32])
		end
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			results();
		end
	end
	initial
	begin
		{rst, rate, rxsel, rstn, psel, pen, pwr, txsel, msel, padr, pwd, s}
			= {7'h40, 50'h0, 8'h48};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Control reset value, writes, read-only and unmapped places
		apb(1'b0, 12'h000, 32'h0, {1'b0, 32'h1, 32'hFFFFFFFF});
		apb(1'b1, 12'h000, 32'h0, 65'h0);
		apb(1'b1, 12'h004, 32'hFFFFFFFF, 65'h0);
		apb(1'b0, 12'h000, 32'h0, {1'b0, 32'h0, 32'hFFFFFFFF});
		apb(1'b1, 12'h000, 32'h1, 65'h0);
		apb(1'b1, 12'h00C, 32'h1, {1'b1, 64'h0});
		apb(1'b0, 12'h00C, 32'h0, {1'b1, 32'h0, 32'hFFFFFFFF});
		for (i = 0; i < 16; i++)
		begin
			@(posedge clk);
			s = lfsr(s);
			// selects move only under transmit reset
			rstn <= 1'b0;
			@(posedge clk);
			{rate, rxsel, txsel, msel} <= {s[3:0], i[3:0]};
			repeat (8) @(posedge clk);
			rstn <= 1'b1;
			repeat (12 * HALF) @(posedge clk);
			md = 4'h3 * lv(msel[3:2]) + lv(msel[1:0]);
			apb(1'b0, 12'h004, 32'h0, {1'b0, 11'h0,
				(rate ? 5'h14 : 5'h0A), 4'h0, md, 3'h0, 1'b1,
				rate && txsel != 2'h0, rate && !rxsel, !rxsel, rate,
				32'hFFFF0FFF});
			apb(1'b0, 12'h008, 32'h0, {1'b0, 32'(2 * HALF), 32'hFFFFFFFF});
			@(posedge refc);
			nbits = 8'h00;
			repeat (8 * HALF)
			begin
				@(negedge clk);
				nbits = nbits + {7'h00, bit_en};
			end
			`CHK(nbits, (rate ? 8'h50 : 8'h28))
		end
		results();
	end
endmodule : tb_transceiver_tx_clock_rate_select
bind tcrs_top tcrs_sva chk (.*);
`default_nettype wire
